//--- logic/bdpc_top.sv
// Duty packet decoder, PWM outputs, supply trim and minimum drain search
//
// Summary of operation
// - Trim level sets output pulse density, level/1024 of 3.3V; reset 0x100.
// - Refresh write sets minimum-drain value to 0x7F, clears its valid bit.
// - Refresh bit self-clears right after being acted on.
// - After refresh scan 32 strings, keep lowest, set valid and scan-done.
// - Every new refresh write restarts a fresh minimum-drain search.
// - Fault clear clears latched fault bits 0-1 (bit 2 follows skip input), re-enables shut-off driver channels.
// - Fault clear keeps over-temp/over-voltage bit if over-temperature set it.
// - Fault-clear bit self-clears after the write that set it.
// - Sync select zero ignores sync pin; main counter wraps freely at 4095.
// - Sync select one wraps main counter on configured sync edge.
// - With sync select one and no sync edges, counter wraps at the fallback wrap value.
// - PWM high for duty main-counter ticks after each wrap; 4095 means always high.
// - Each duty loads its channel's one-shot down-counter setting high time.
// - New duties take effect at first wrap after chip select rises.
// - Duty slots 12 bits, channel 31 at bits 64-75 down to channel 0.
// - Read bits 0-371 carry no content.
// - Read bits 372-383 echo ADC start delay from the cfg input, which has no reset.
// - Read bits 384-389 report second ADC channel from previous write.
// - Read bits 392-397 report first ADC channel from previous write.
// - Packet is 448 bits, MSB first; equal-length read stream returned.
// - Input sampled on rising serial clock, output changes on falling edge.
`timescale 1ns/10ps

module bdpc_top #(
    parameter int unsigned NUM_CH = 32,
    parameter int unsigned DIV_W  = 8
) (
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    input  wire logic                        spi_sclk,
    input  wire logic                        spi_cs_b,
    input  wire logic                        spi_sdi,
    output logic                             spi_sdo,
    input  wire logic [1:0]                  packet_type_sel,
    input  wire logic                        sync_in,
    input  wire bdpc_pkg::bdpc_cfg_t         cfg,
    input  wire bdpc_pkg::bdpc_drain_sample_t drain_sample,
    input  wire logic                        fault_uv_evt,
    input  wire logic                        fault_ov_evt,
    input  wire logic                        fault_ot_evt,
    input  wire logic                        skip_any,
    output logic                             supply_trim_out,
    output logic [NUM_CH-1:0]                led_out,
    output logic [5:0]                       adc_a_channel_select,
    output logic [5:0]                       adc_b_channel_select,
    output bdpc_pkg::bdpc_min_report_t       min_drain_report,
    output logic                             scan_done,
    output logic [2:0]                       global_fault,
    output logic                             driver_reenable
);

    // ==========================================================
    // Pin synchronisers: bit 0 sclk, 1 cs, 2 sdi, 3 sync, 5:4 type
    localparam logic [5:0] PIN_RST = 6'h02;

    logic [5:0] pin_s1_reg;
    logic [5:0] pin_s2_reg;
    logic [5:0] pin_s3_reg;
    logic [5:0] pin_reg;
    logic [5:0] pin_raw;

    assign pin_raw = {packet_type_sel, sync_in, spi_sdi, spi_cs_b, spi_sclk};

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_s1_reg <= PIN_RST;
            pin_s2_reg <= PIN_RST;
            pin_s3_reg <= PIN_RST;
            pin_reg    <= PIN_RST;
        end
        else
        begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            // Change counts once stages two and three agree
            pin_reg    <= (pin_s2_reg & pin_s3_reg)
                        | (pin_reg & (pin_s2_reg ^ pin_s3_reg));
        end
    end

    logic [5:0] pin_prev_reg;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            pin_prev_reg <= PIN_RST;
        else
            pin_prev_reg <= pin_reg;
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic cs_active;

    assign sclk_rise = pin_reg[0] & ~pin_prev_reg[0];
    assign sclk_fall = ~pin_reg[0] & pin_prev_reg[0];
    assign cs_fall   = ~pin_reg[1] & pin_prev_reg[1];
    assign cs_rise   = pin_reg[1] & ~pin_prev_reg[1];
    assign cs_active = ~pin_reg[1];

    // ==========================================================
    // Serial shift registers
    logic [bdpc_pkg::PKT_BITS-1:0] rx_shift_reg;
    logic [bdpc_pkg::PKT_BITS-1:0] tx_shift_reg;
    logic [bdpc_pkg::PKT_BITS-1:0] tx_load;
    logic [bdpc_pkg::CNT_W-1:0]    bit_cnt_reg;
    logic                          type_ok_reg;
    logic                          overrun_reg;

    always_comb
    begin
        tx_load = '0;
        tx_load[bdpc_pkg::RD_DELAY_LSB +: 12] = cfg.adc_start_delay;
        tx_load[bdpc_pkg::RD_BECHO_LSB +: 6]  = adc_b_channel_select;
        tx_load[bdpc_pkg::RD_AECHO_LSB +: 6]  = adc_a_channel_select;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            rx_shift_reg <= '0;
        else if (cs_active && sclk_rise)
            rx_shift_reg <= {rx_shift_reg[bdpc_pkg::PKT_BITS-2:0],
                             pin_reg[2]};
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            tx_shift_reg <= '0;
        else if (cs_fall)
            tx_shift_reg <= tx_load;
        else if (cs_active && sclk_fall)
            tx_shift_reg <= {tx_shift_reg[bdpc_pkg::PKT_BITS-2:0],
                             1'b0};
    end

    assign spi_sdo = tx_shift_reg[bdpc_pkg::PKT_BITS-1];

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bit_cnt_reg <= '0;
            overrun_reg <= 1'b0;
        end
        else if (cs_fall)
        begin
            bit_cnt_reg <= '0;
            overrun_reg <= 1'b0;
        end
        else if (cs_active && sclk_rise)
        begin
            if (bit_cnt_reg == bdpc_pkg::PKT_BITS_C)
                overrun_reg <= 1'b1;
            else
                bit_cnt_reg <= bit_cnt_reg + 9'h001;
        end
    end

    // Packet type must stay duty type for the whole transaction
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            type_ok_reg <= 1'b0;
        else if (cs_fall)
            type_ok_reg <= (pin_reg[5:4] == 2'b00);
        else if (cs_active && pin_reg[5:4] != 2'b00)
            type_ok_reg <= 1'b0;
    end

    logic commit;

    // Only a complete duty packet is taken; anything else is dropped
    assign commit = cs_rise && type_ok_reg && !overrun_reg
                 && (bit_cnt_reg == bdpc_pkg::PKT_BITS_C);

    // ==========================================================
    // Control fields
    logic [9:0] trim_level_reg;
    logic       sync_select_reg;
    logic       refresh_pulse_reg;
    logic       clear_pulse_reg;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            trim_level_reg       <= bdpc_pkg::TRIM_RST;
            sync_select_reg      <= 1'b0;
            adc_a_channel_select <= bdpc_pkg::CHSEL_RST;
            adc_b_channel_select <= bdpc_pkg::CHSEL_RST;
        end
        else if (commit)
        begin
            // Reserved bits are never looked at
            trim_level_reg <= rx_shift_reg[bdpc_pkg::WR_TRIM_LSB +: 10];
            sync_select_reg      <= rx_shift_reg[bdpc_pkg::WR_SYNCSEL_BIT];
            adc_a_channel_select <= rx_shift_reg[bdpc_pkg::WR_ASEL_LSB +: 6];
            adc_b_channel_select <= rx_shift_reg[bdpc_pkg::WR_BSEL_LSB +: 6];
        end
    end

    // Command bits live one cycle only
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            refresh_pulse_reg <= 1'b0;
            clear_pulse_reg   <= 1'b0;
        end
        else
        begin
            refresh_pulse_reg <= commit
                && rx_shift_reg[bdpc_pkg::WR_REFRESH_BIT];
            clear_pulse_reg   <= commit
                && rx_shift_reg[bdpc_pkg::WR_CLEAR_BIT];
        end
    end

    assign driver_reenable = clear_pulse_reg;

    // ==========================================================
    // Supply trim pulse density
    logic [9:0] trim_acc_reg;
    logic [10:0] trim_sum;

    assign trim_sum = {1'b0, trim_acc_reg} + {1'b0, trim_level_reg};

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            trim_acc_reg    <= '0;
            supply_trim_out <= 1'b0;
        end
        else
        begin
            trim_acc_reg    <= trim_sum[9:0];
            supply_trim_out <= trim_sum[10];
        end
    end

    // ==========================================================
    // Minimum drain search
    logic [5:0] scan_cnt_reg;
    logic       scanning_reg;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            min_drain_report.valid <= 1'b0;
            min_drain_report.level <= bdpc_pkg::MIN_DRAIN_TOP;
            min_drain_report.ch    <= '0;
            scan_done              <= 1'b0;
            scanning_reg           <= 1'b0;
            scan_cnt_reg           <= '0;
        end
        else if (refresh_pulse_reg)
        begin
            min_drain_report.valid <= 1'b0;
            min_drain_report.level <= bdpc_pkg::MIN_DRAIN_TOP;
            scan_done              <= 1'b0;
            scanning_reg           <= 1'b1;
            scan_cnt_reg           <= '0;
        end
        else if (scanning_reg && drain_sample.valid)
        begin
            if (drain_sample.level < min_drain_report.level)
            begin
                min_drain_report.level <= drain_sample.level;
                min_drain_report.ch    <= drain_sample.ch;
            end
            scan_cnt_reg <= scan_cnt_reg + 6'h01;
            if (scan_cnt_reg == bdpc_pkg::SCAN_COUNT - 6'h01)
            begin
                scanning_reg           <= 1'b0;
                min_drain_report.valid <= 1'b1;
                scan_done              <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Global fault bits; a new event wins over the clear
    logic ot_cause_reg;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            global_fault <= 3'h0;
            ot_cause_reg <= 1'b0;
        end
        else
        begin
            global_fault[0] <= fault_uv_evt
                | (global_fault[0] & ~clear_pulse_reg);
            global_fault[1] <= fault_ov_evt | fault_ot_evt
                | (global_fault[1] & ~(clear_pulse_reg & ~ot_cause_reg));
            global_fault[2] <= skip_any;
            if (fault_ot_evt)
                ot_cause_reg <= 1'b1;
            else if (clear_pulse_reg && !global_fault[1])
                ot_cause_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Main counter with frame divider tick
    logic [DIV_W-1:0]  div_cnt_reg;
    logic              tick;
    logic [12:0]       main_cnt_reg;
    logic              wrap;
    logic              sync_edge;
    logic              sync_hit;
    logic [12:0]       wrap_at;

    assign tick = (div_cnt_reg == cfg.frame_divider);

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            div_cnt_reg <= '0;
        else if (tick || sync_hit)
            div_cnt_reg <= '0;
        else
            div_cnt_reg <= div_cnt_reg + DIV_W'(1);
    end

    assign sync_edge = cfg.sync_edge_rise
                     ? (pin_reg[3] & ~pin_prev_reg[3])
                     : (~pin_reg[3] & pin_prev_reg[3]);
    assign sync_hit  = sync_select_reg & sync_edge;
    assign wrap_at   = sync_select_reg ? cfg.fallback_wrap_value
                                       : bdpc_pkg::FREE_WRAP;
    assign wrap      = sync_hit || (tick && main_cnt_reg >= wrap_at);

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            main_cnt_reg <= '0;
        else if (wrap)
            main_cnt_reg <= '0;
        else if (tick)
            main_cnt_reg <= main_cnt_reg + 13'h0001;
    end

    // ==========================================================
    // Duty staging and per-channel one-shots
    logic pending_reg;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            pending_reg <= 1'b0;
        else if (commit)
            pending_reg <= 1'b1;
        else if (wrap)
            pending_reg <= 1'b0;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_ch
            localparam int unsigned SLOT =
                bdpc_pkg::WR_DUTY31_LSB + 12 * (NUM_CH - 1 - gi);
            logic [11:0] staged_reg;
            logic [11:0] active_reg;
            logic [11:0] down_reg;

            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                    staged_reg <= bdpc_pkg::DUTY_RST;
                else if (commit)
                    staged_reg <= rx_shift_reg[SLOT +: 12];
            end

            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                    active_reg <= bdpc_pkg::DUTY_RST;
                else if (wrap && pending_reg)
                    active_reg <= staged_reg;
            end

            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                    down_reg <= '0;
                else if (wrap)
                    down_reg <= (pending_reg ? staged_reg
                                             : active_reg);
                else if (tick && down_reg != 12'h000)
                    down_reg <= down_reg - 12'h001;
            end

            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                    led_out[gi] <= 1'b0;
                else
                    led_out[gi] <= (active_reg == bdpc_pkg::DUTY_FULL)
                                 || (down_reg != 12'h000);
            end
        end
    endgenerate

endmodule : bdpc_top

//--- logic/bdpc_pkg.sv
// Constants and carrier types of the backlight duty packet control block
package bdpc_pkg;

    // ==========================================================
    // Packet geometry
    localparam int unsigned PKT_BITS   = 448;
    localparam int unsigned CNT_W      = 9;
    localparam int unsigned NUM_CH     = 32;
    localparam int unsigned DUTY_W     = 12;
    localparam int unsigned MAIN_W     = 13;
    localparam int unsigned DIV_W      = 8;

    // ==========================================================
    // Write packet field positions (lsb)
    localparam int unsigned WR_BSEL_LSB    = 32;
    localparam int unsigned WR_ASEL_LSB    = 40;
    localparam int unsigned WR_TRIM_LSB    = 48;
    localparam int unsigned WR_REFRESH_BIT = 60;
    localparam int unsigned WR_CLEAR_BIT   = 61;
    localparam int unsigned WR_SYNCSEL_BIT = 62;
    localparam int unsigned WR_DUTY31_LSB  = 64;

    // ==========================================================
    // Read packet field positions (lsb)
    localparam int unsigned RD_DELAY_LSB = 372;
    localparam int unsigned RD_BECHO_LSB = 384;
    localparam int unsigned RD_AECHO_LSB = 392;

    // ==========================================================
    // Reset values and fixed counts
    localparam logic [9:0]  TRIM_RST      = 10'h100;
    localparam logic [11:0] DELAY_RST     = 12'h003;
    localparam logic [5:0]  CHSEL_RST     = 6'h00;
    localparam logic [11:0] DUTY_RST      = 12'h000;
    localparam logic [11:0] DUTY_FULL     = 12'hfff;
    localparam logic [12:0] FREE_WRAP     = 13'h0fff;
    localparam logic [6:0]  MIN_DRAIN_TOP = 7'h7f;
    localparam logic [5:0]  SCAN_COUNT    = 6'h20;
    localparam logic [CNT_W-1:0] PKT_BITS_C = 9'h1c0;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic [11:0] adc_start_delay;
        logic [7:0]  frame_divider;
        logic        sync_edge_rise;
        logic [12:0] fallback_wrap_value;
    } bdpc_cfg_t;

    typedef struct packed {
        logic       valid;
        logic [4:0] ch;
        logic [6:0] level;
    } bdpc_drain_sample_t;

    typedef struct packed {
        logic       valid;
        logic [4:0] ch;
        logic [6:0] level;
    } bdpc_min_report_t;

endpackage : bdpc_pkg

//--- verification/bdpc_monitor.sv
// Port assertions for the duty packet control block
`timescale 1ns/10ps
module bdpc_monitor #(
    parameter int unsigned NUM_CH = 32,
    parameter int unsigned DIV_W  = 8
) (
    input wire logic                          mclk,
    input wire logic                          rst_b,
    input wire logic                          spi_sclk,
    input wire logic                          spi_cs_b,
    input wire logic                          spi_sdi,
    input wire logic                          spi_sdo,
    input wire logic [1:0]                    packet_type_sel,
    input wire logic                          sync_in,
    input wire bdpc_pkg::bdpc_cfg_t           cfg,
    input wire bdpc_pkg::bdpc_drain_sample_t  drain_sample,
    input wire logic                          fault_uv_evt,
    input wire logic                          fault_ov_evt,
    input wire logic                          fault_ot_evt,
    input wire logic                          skip_any,
    input wire logic                          supply_trim_out,
    input wire logic [NUM_CH-1:0]             led_out,
    input wire logic [5:0]                    adc_a_channel_select,
    input wire logic [5:0]                    adc_b_channel_select,
    input wire bdpc_pkg::bdpc_min_report_t    min_drain_report,
    input wire logic                          scan_done,
    input wire logic [2:0]                    global_fault,
    input wire logic                          driver_reenable
);
    // ==========================================================
    // Recent falls of serial clock or select at the pins
    logic [7:0] fall_hist;
    logic       sclk_d;
    logic       cs_d;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fall_hist <= 8'h00;
            sclk_d    <= 1'b0;
            cs_d      <= 1'b1;
        end
        else
        begin
            sclk_d    <= spi_sclk;
            cs_d      <= spi_cs_b;
            fall_hist <= {fall_hist[6:0],
                          (sclk_d & ~spi_sclk) | (cs_d & ~spi_cs_b)};
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // ==========================================================
    // Assertions
    a_sdo_after_fall: assert property (
        $changed(spi_sdo) |-> |fall_hist[7:1])
        else $error("serial output moved without a clock or select fall");
    a_clear_one_cycle: assert property (
        driver_reenable |=> !driver_reenable)
        else $error("reenable pulse longer than one cycle");
    a_clear_drops_uv: assert property (
        driver_reenable && !fault_uv_evt |=> !global_fault[0])
        else $error("fault clear left the undervoltage bit set");
    a_uv_fall_cause: assert property (
        $fell(global_fault[0]) |-> driver_reenable || $past(driver_reenable))
        else $error("undervoltage bit dropped without a clear");
    a_refresh_resets: assert property (
        $fell(scan_done) |-> min_drain_report.level == 7'h7f
            && !min_drain_report.valid)
        else $error("refresh did not preset the minimum report");
    a_done_with_valid: assert property (
        $rose(scan_done) |-> min_drain_report.valid)
        else $error("scan done without a valid report");
    a_report_holds: assert property (
        scan_done && $past(scan_done) |-> $stable(min_drain_report))
        else $error("report moved after the scan finished");
    a_sel_on_commit: assert property (
        $changed(adc_a_channel_select) || $changed(adc_b_channel_select)
            |-> spi_cs_b && $past(spi_cs_b, 4))
        else $error("channel select changed inside a transaction");
endmodule : bdpc_monitor

//--- verification/bdpc_host.sv
// Serial host model that shifts duty packets
`timescale 1ns/10ps
module bdpc_host (
    input  wire logic  mclk,
    input  wire logic  spi_sdo,
    output logic       spi_sclk,
    output logic       spi_cs_b,
    output logic       spi_sdi,
    output logic [1:0] packet_type_sel
);
    // ==========================================================
    // Packet transfer, six system clocks per serial phase
    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_b = 1'b1;
        spi_sdi = 1'b0;
        packet_type_sel = 2'b11;
    end

    task automatic xfer(input logic [447:0] w, input logic [1:0] typ,
                        output logic [447:0] r);
        @(posedge mclk);
        packet_type_sel <= typ;
        repeat (8) @(posedge mclk);
        spi_cs_b <= 1'b0;
        repeat (8) @(posedge mclk);
        for (int i = 447; i >= 0; i--)
        begin
            spi_sdi <= w[i];
            repeat (6) @(posedge mclk);
            r[i] = spi_sdo;
            spi_sclk <= 1'b1;
            repeat (6) @(posedge mclk);
            spi_sclk <= 1'b0;
        end
        repeat (6) @(posedge mclk);
        spi_cs_b <= 1'b1;
        spi_sdi <= ~spi_sdi;
        repeat (40) @(posedge mclk);
    endtask : xfer
endmodule : bdpc_host

//--- verification/bdpc_top_tb.sv
// Self-checking bench for the duty packet control block
`timescale 1ns/10ps
module bdpc_top_tb;
    // ==========================================================
    // Rows: channel selects and delay setting per packet
    typedef struct packed {
        logic [5:0]  a;
        logic [5:0]  b;
        logic [11:0] dly;
    } bdpc_row_t;
    localparam bdpc_row_t ROWS [3] = '{'{6'h05, 6'h20, 12'h003},
        '{6'h1f, 6'h00, 12'h5a6}, '{6'h20, 6'h11, 12'hfff}};

    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic spi_sclk, spi_cs_b, spi_sdi, spi_sdo, supply_trim_out;
    logic scan_done, driver_reenable;
    logic sync_in = 1'b0;
    logic skip_any = 1'b0;
    logic fault_uv_evt = 1'b0;
    logic fault_ov_evt = 1'b0;
    logic fault_ot_evt = 1'b0;
    logic sync_run = 1'b0;
    logic [1:0] packet_type_sel;
    logic [31:0] led_out;
    logic [5:0] adc_a_channel_select, adc_b_channel_select;
    logic [2:0] global_fault;
    bdpc_pkg::bdpc_cfg_t cfg = '0;
    bdpc_pkg::bdpc_drain_sample_t drain_sample = '0;
    bdpc_pkg::bdpc_min_report_t min_drain_report;
    logic [11:0] duty [32];
    logic [9:0] trim_v = 10'h100;
    logic [447:0] rd;
    int num_errors = 0;
    int num_checks = 0;
    int reen_cnt = 0;
    int sync_cnt = 0;
    int hi_cnt [33];

    bdpc_top i_dut (.*);
    bdpc_host i_host (.*);

    always #25 mclk = ~mclk;
    always @(negedge mclk) if (driver_reenable === 1'b1) reen_cnt++;
    always @(posedge mclk)
    begin
        if (sync_run)
        begin
            sync_cnt <= (sync_cnt == 999) ? 0 : sync_cnt + 1;
            sync_in <= (sync_cnt < 4);
        end
    end

    // ==========================================================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic pkt(input logic [5:0] a, input logic [5:0] b,
                       input logic [2:0] ctl);
        logic [447:0] p;
        p = '0;
        p[37:32] = b;
        p[45:40] = a;
        p[57:48] = trim_v;
        p[62:60] = ctl;
        p[47:46] = 2'b11;
        p[59:58] = 2'b11;
        p[63] = 1'b1;
        for (int c = 0; c < 32; c++)
            p[64 + 12 * (31 - c) +: 12] = duty[c];
        i_host.xfer(p, 2'b00, rd);
        @(negedge mclk);
    endtask : pkt

    task automatic count(input int n);
        hi_cnt = '{default: 0};
        repeat (n)
        begin
            @(negedge mclk);
            for (int c = 0; c < 32; c++)
                hi_cnt[c] += led_out[c];
            hi_cnt[32] += supply_trim_out;
        end
    endtask : count

    task automatic chk_pwm(input int per, input int n);
        int e;
        count(per * n);
        for (int c = 0; c < 32; c++)
        begin
            e = (duty[c] == 12'hfff || duty[c] >= per) ? per : duty[c];
            chk("led high", n * e, hi_cnt[c]);
        end
    endtask : chk_pwm

    task automatic scan(input int n, input int base, input int off);
        for (int k = 0; k < n; k++)
        begin
            @(posedge mclk);
            drain_sample <= {1'b1, 5'(k), 7'(base + 2 * ((k + off) % 32))};
            @(posedge mclk);
            drain_sample.valid <= 1'b0;
        end
    endtask : scan

    task automatic evt(input logic [2:0] m);
        @(posedge mclk);
        {fault_ot_evt, fault_ov_evt, fault_uv_evt} <= m;
        @(posedge mclk);
        {fault_ot_evt, fault_ov_evt, fault_uv_evt} <= 3'b000;
        repeat (3) @(posedge mclk);
    endtask : evt

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (100000) @(posedge mclk);
        num_errors++;
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        for (int c = 0; c < 32; c++)
            duty[c] = 12'(c * 127);
        duty[31] = 12'hfff;
        cfg.fallback_wrap_value <= 13'h07ff;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        count(1024);
        chk("trim density", 256, hi_cnt[32]);
        for (int i = 0; i < 3; i++)
        begin
            cfg.adc_start_delay <= ROWS[i].dly;
            pkt(ROWS[i].a, ROWS[i].b, 3'b000);
            chk("delay echo", ROWS[i].dly, rd[383:372]);
            chk("b echo", i ? ROWS[i-1].b : 6'h00, rd[389:384]);
            chk("a echo", i ? ROWS[i-1].a : 6'h00, rd[397:392]);
        end
        chk_pwm(4096, 1);
        i_host.xfer('1, 2'b01, rd);
        trim_v = 10'h2a5;
        pkt(6'h01, 6'h02, 3'b000);
        chk("a after refused", ROWS[2].a, rd[397:392]);
        count(1024);
        chk("trim density", 32'h2a5, hi_cnt[32]);
        pkt(6'h01, 6'h02, 3'b001);
        chk("report level", 7'h7f, min_drain_report.level);
        chk("scan done", 0, scan_done);
        scan(10, 0, 0);
        pkt(6'h01, 6'h02, 3'b001);
        scan(32, 5, 19);
        repeat (4) @(negedge mclk);
        chk("min level", 5, min_drain_report.level);
        chk("min channel", 13, min_drain_report.ch);
        chk("report valid", 1, min_drain_report.valid);
        chk("scan done", 1, scan_done);
        skip_any <= 1'b1;
        evt(3'b011);
        chk("faults set", 3'b111, global_fault);
        trim_v = 10'h3ff;
        skip_any <= 1'b0;
        pkt(6'h01, 6'h02, 3'b010);
        chk("faults cleared", 3'b000, global_fault);
        chk("report kept", 1, scan_done);
        evt(3'b100);
        pkt(6'h01, 6'h02, 3'b011);
        chk("ot kept", 3'b010, global_fault);
        evt(3'b001);
        pkt(6'h01, 6'h02, 3'b000);
        chk("clear not sticky", 3'b011, global_fault);
        chk("reenable pulses", 2, reen_cnt);
        pkt(6'h01, 6'h02, 3'b100);
        repeat (2048) @(posedge mclk);
        chk_pwm(2048, 2);
        sync_run <= 1'b1;
        for (int e = 1; e >= 0; e--)
        begin
            cfg.sync_edge_rise <= e[0];
            repeat (2000) @(posedge mclk);
            chk_pwm(1000, 2);
        end
        pkt(6'h01, 6'h02, 3'b000);
        repeat (4096) @(posedge mclk);
        chk_pwm(4096, 1);
        test_done();
    end
endmodule : bdpc_top_tb

bind bdpc_top bdpc_monitor #(.NUM_CH(NUM_CH), .DIV_W(DIV_W)) i_mon (.*);
